// file: tfm_pkg.sv
package tfm_pkg;
  localparam logic [6:0] TFM_ADDR_DEFAULT = 7'h2e;
  localparam logic [4:0] TFM_ADDR_PREFIX = 5'h0b;
  localparam logic [7:0] TFM_PTR_VALUE = 8'h20;
  localparam logic [7:0] TFM_PTR_DUTY = 8'h30;
  localparam logic [7:0] TFM_PTR_CONFIG = 8'h40;
  localparam logic [7:0] TFM_PTR_STATUS = 8'h41;
  localparam logic [7:0] TFM_PTR_MASK = 8'h42;
  localparam logic [3:0] TFM_PTR_MEM = 4'h5;
  localparam logic [7:0] TFM_PTR_START = 8'h60;
  localparam logic [7:0] TFM_PTR_RANGE = 8'h64;
  localparam logic [7:0] TFM_PTR_ACOUS = 8'h68;
  localparam logic [1:0] TFM_MF_OFFSET = 2'h0;
  localparam logic [1:0] TFM_MF_LOW = 2'h1;
  localparam logic [1:0] TFM_MF_HIGH = 2'h2;
  localparam logic [1:0] TFM_MF_OPPT = 2'h3;
  localparam int TFM_CFG_RUN = 0;
  localparam int TFM_CFG_ALERT_A = 1;
  localparam int TFM_CFG_ALERT_B = 2;
  localparam int TFM_CFG_DYN = 3;
  localparam logic [7:0] TFM_CONFIG_RST = 8'h00;
  localparam logic [7:0] TFM_MASK_RST = 8'h00;
  localparam logic [7:0] TFM_START_RST = 8'h40;
  localparam logic [7:0] TFM_RANGE_RST = 8'h02;
  localparam logic [7:0] TFM_ACOUS_RST = 8'h00;
  localparam logic [7:0] TFM_LOW_RST = 8'h00;
  localparam logic [7:0] TFM_HIGH_RST = 8'hff;
  localparam logic [4:0] TFM_AV_STATUS = 5'h00;
  localparam logic [4:0] TFM_AV_ENABLE = 5'h04;
  localparam logic [4:0] TFM_AV_CLEAR = 5'h08;
  localparam logic [4:0] TFM_AV_STATE = 5'h0c;
  localparam int TFM_EV_CYCLE = 0;
  localparam int TFM_EV_LIMIT = 1;
  localparam int TFM_EV_WRITE = 2;
  localparam int TFM_NUM_EV = 3;
endpackage

// file: tfm_regmem.sv
`timescale 1ns/1ps
module tfm_regmem
  import tfm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic a_we,
  input wire logic [3:0] a_addr,
  input wire logic [7:0] a_wdata,
  output logic [7:0] a_rdata,
  input wire logic [3:0] b_addr,
  output logic [7:0] b_rdata
);
  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [7:0] a_rd;
    logic [7:0] b_rd;
  } tfm_mem_t;
  tfm_mem_t q, d;

  always_comb begin
    d = q;
    if (a_we) begin
      d.mem[a_addr] = a_wdata;
    end
    d.a_rd = q.mem[a_addr];
    d.b_rd = q.mem[b_addr];
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        q.mem[i] <= (i[3:2] == TFM_MF_HIGH) ? TFM_HIGH_RST : TFM_LOW_RST;
      end
      q.a_rd <= 8'h00;
      q.b_rd <= 8'h00;
    end else begin
      q <= d;
    end
  end

  assign a_rdata = q.a_rd;
  assign b_rdata = q.b_rd;
endmodule

// file: tfm_seq.sv
`timescale 1ns/1ps
module tfm_seq
  import tfm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  input wire logic hold,
  input wire logic adc_done,
  input wire logic [7:0] adc_data,
  output logic adc_start,
  output logic [1:0] adc_ch,
  output logic res_valid,
  output logic [1:0] res_ch,
  output logic [7:0] res_data,
  output logic cycle_done
);
  typedef enum logic {SQ_IDLE, SQ_WAIT} tfm_sq_t;
  typedef struct packed {
    tfm_sq_t st;
    logic [1:0] ch;
    logic start;
    logic valid;
    logic [1:0] rch;
    logic [7:0] rdata;
    logic cdone;
  } tfm_seq_t;
  tfm_seq_t q, d;

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.valid = 1'b0;
    d.cdone = 1'b0;
    unique case (q.st)
      SQ_IDLE: begin
        if (run && !hold) begin
          d.start = 1'b1;
          d.st = SQ_WAIT;
        end
      end
      SQ_WAIT: begin
        if (adc_done) begin
          d.valid = 1'b1;
          d.rch = q.ch;
          d.rdata = adc_data;
          d.ch = 2'(q.ch + 2'd1);
          d.cdone = (q.ch == 2'd3);
          d.st = SQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '{st: SQ_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign adc_start = q.start;
  assign adc_ch = q.ch;
  assign res_valid = q.valid;
  assign res_ch = q.rch;
  assign res_data = q.rdata;
  assign cycle_done = q.cdone;

  seq_step_a: assert property (@(posedge mclk) disable iff (reset)
    q.valid |-> q.ch == 2'(q.rch + 2'd1)) else $error("channel did not advance");
endmodule

// file: tfm_core.sv
`timescale 1ns/1ps
module tfm_core
  import tfm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_en_in,
  input wire logic addr_sel_in,
  output logic alert_a_out,
  output logic alert_a_oe,
  output logic alert_b_out,
  output logic alert_b_oe,
  output logic adc_start,
  output logic [1:0] adc_ch,
  input wire logic adc_done,
  input wire logic [7:0] adc_data,
  output logic [23:0] fan_duty,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);
  typedef enum logic [2:0] {SM_IDLE, SM_ADDR, SM_AACK, SM_WR, SM_WACK, SM_RD, SM_RACK} tfm_sm_t;
  typedef enum logic [2:0] {P_IDLE, P_OFS, P_LOW, P_HIGH, P_CMP, P_FAN} tfm_pr_t;
  typedef struct packed {
    tfm_sm_t smb;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitcnt;
    logic [1:0] bytecnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic rw;
    logic sda_oe;
    logic [7:0] ptr;
    logic [6:0] addr;
    logic strap_done;
    logic [7:0] config_r;
    logic [7:0] mask;
    logic [7:0] status;
    logic [7:0] cond;
    logic [3:0][7:0] value;
    logic [2:0][7:0] start;
    logic [2:0][7:0] range;
    logic [2:0][7:0] acous;
    logic [2:0][7:0] duty;
    tfm_pr_t proc;
    logic [1:0] pch;
    logic [7:0] praw;
    logic [7:0] pval;
    logic plow;
    logic av_wait;
    logic [31:0] av_rdata;
    logic [TFM_NUM_EV-1:0] ev_status;
    logic [TFM_NUM_EV-1:0] ev_en;
    logic irq;
    logic alert_a;
    logic alert_b;
  } tfm_core_t;
  tfm_core_t q, d;

  logic mem_we;
  logic [3:0] mem_b_addr;
  logic [7:0] mem_a_rdata;
  logic [7:0] mem_b_rdata;
  logic res_valid;
  logic [1:0] res_ch;
  logic [7:0] res_data;
  logic cycle_done;
  logic scl_rise, scl_fall, smb_start, smb_stop;
  logic wr_en;
  logic [7:0] rd_byte;
  logic [7:0] st_set, st_clr;
  logic [TFM_NUM_EV-1:0] ev_set, ev_clr;
  logic [7:0] held;

  tfm_regmem u_mem (
    .mclk(mclk),
    .reset(reset),
    .a_we(mem_we),
    .a_addr(q.ptr[3:0]),
    .a_wdata(q.sh),
    .a_rdata(mem_a_rdata),
    .b_addr(mem_b_addr),
    .b_rdata(mem_b_rdata)
  );

  tfm_seq u_seq (
    .mclk(mclk),
    .reset(reset),
    .run(q.config_r[TFM_CFG_RUN]),
    .hold(q.proc != P_IDLE || res_valid),
    .adc_done(adc_done),
    .adc_data(adc_data),
    .adc_start(adc_start),
    .adc_ch(adc_ch),
    .res_valid(res_valid),
    .res_ch(res_ch),
    .res_data(res_data),
    .cycle_done(cycle_done)
  );

  assign scl_rise = scl_in && !q.scl_q;
  assign scl_fall = !scl_in && q.scl_q;
  assign smb_start = scl_in && q.scl_q && q.sda_q && !sda_in;
  assign smb_stop = scl_in && q.scl_q && !q.sda_q && sda_in;
  assign held = q.status & q.cond;

  always_comb begin
    rd_byte = 8'h00;
    if (q.ptr[7:2] == TFM_PTR_VALUE[7:2]) begin
      rd_byte = q.value[q.ptr[1:0]];
    end else if (q.ptr[7:4] == TFM_PTR_MEM) begin
      rd_byte = mem_a_rdata;
    end else if (q.ptr == TFM_PTR_CONFIG) begin
      rd_byte = q.config_r;
    end else if (q.ptr == TFM_PTR_STATUS) begin
      rd_byte = q.status;
    end else if (q.ptr == TFM_PTR_MASK) begin
      rd_byte = q.mask;
    end else if (q.ptr[1:0] != 2'd3) begin
      if (q.ptr[7:2] == TFM_PTR_START[7:2]) begin
        rd_byte = q.start[q.ptr[1:0]];
      end else if (q.ptr[7:2] == TFM_PTR_RANGE[7:2]) begin
        rd_byte = q.range[q.ptr[1:0]];
      end else if (q.ptr[7:2] == TFM_PTR_ACOUS[7:2]) begin
        rd_byte = q.acous[q.ptr[1:0]];
      end else if (q.ptr[7:2] == TFM_PTR_DUTY[7:2]) begin
        rd_byte = q.duty[q.ptr[1:0]];
      end
    end
  end

  always_comb begin
    logic [1:0] p;
    logic [7:0] diff, tgt, step, cur;
    logic [15:0] slope;
    p = 2'(q.pch - 2'd1);
    diff = 8'h00;
    tgt = 8'h00;
    step = 8'h00;
    cur = 8'h00;
    slope = 16'h0000;
    d = q;
    mem_we = 1'b0;
    mem_b_addr = 4'h0;
    wr_en = 1'b0;
    st_set = 8'h00;
    st_clr = 8'h00;
    ev_clr = '0;
    d.scl_q = scl_in;
    d.sda_q = sda_in;
    if (!q.strap_done) begin
      d.strap_done = 1'b1;
      d.addr = addr_en_in ? TFM_ADDR_DEFAULT : {TFM_ADDR_PREFIX, 1'b0, addr_sel_in};
    end
    unique case (q.smb)
      SM_IDLE: begin
      end
      SM_ADDR, SM_WR: begin
        if (scl_rise) begin
          d.sh = {q.sh[6:0], sda_in};
          d.bitcnt = 4'(q.bitcnt + 4'd1);
        end else if (scl_fall && q.bitcnt == 4'd8) begin
          d.bitcnt = 4'd0;
          if (q.smb == SM_ADDR) begin
            if (q.sh[7:1] == q.addr) begin
              d.sda_oe = 1'b1;
              d.rw = q.sh[0];
              d.smb = SM_AACK;
            end else begin
              d.smb = SM_IDLE;
            end
          end else begin
            d.smb = SM_WACK;
            if (q.bytecnt != 2'd2) begin
              d.sda_oe = 1'b1;
              d.bytecnt = 2'(q.bytecnt + 2'd1);
              if (q.bytecnt == 2'd0) begin
                d.ptr = q.sh;
              end else begin
                wr_en = 1'b1;
              end
            end
          end
        end
      end
      SM_AACK: begin
        if (scl_fall) begin
          if (q.rw) begin
            d.tx = rd_byte;
            d.sda_oe = !rd_byte[7];
            d.smb = SM_RD;
            if (q.ptr == TFM_PTR_STATUS) begin
              st_clr = ~q.cond;
            end
          end else begin
            d.sda_oe = 1'b0;
            d.smb = SM_WR;
          end
        end
      end
      SM_WACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.smb = SM_WR;
        end
      end
      SM_RD: begin
        if (scl_fall) begin
          if (q.bitcnt == 4'd7) begin
            d.sda_oe = 1'b0;
            d.smb = SM_RACK;
          end else begin
            d.tx = {q.tx[6:0], 1'b0};
            d.sda_oe = !q.tx[6];
            d.bitcnt = 4'(q.bitcnt + 4'd1);
          end
        end
      end
      SM_RACK: begin
        if (scl_rise) begin
          d.smb = SM_IDLE;
        end
      end
    endcase
    if (smb_start) begin
      d.smb = SM_ADDR;
      d.bitcnt = 4'd0;
      d.bytecnt = 2'd0;
      d.sda_oe = 1'b0;
    end else if (smb_stop) begin
      d.smb = SM_IDLE;
      d.sda_oe = 1'b0;
    end
    unique case (q.proc)
      P_IDLE: begin
        if (res_valid) begin
          d.pch = res_ch;
          d.praw = res_data;
          d.proc = P_OFS;
        end
      end
      P_OFS: begin
        mem_b_addr = {TFM_MF_OFFSET, q.pch};
        d.proc = P_LOW;
      end
      P_LOW: begin
        d.pval = (q.pch == 2'd0) ? q.praw : 8'(q.praw + mem_b_rdata);
        mem_b_addr = {TFM_MF_LOW, q.pch};
        d.proc = P_HIGH;
      end
      P_HIGH: begin
        d.plow = q.pval < mem_b_rdata;
        mem_b_addr = {TFM_MF_HIGH, q.pch};
        d.proc = P_CMP;
      end
      P_CMP: begin
        d.value[q.pch] = q.pval;
        d.cond[q.pch] = q.plow || (q.pval > mem_b_rdata);
        st_set[q.pch] = q.plow || (q.pval > mem_b_rdata);
        mem_b_addr = {TFM_MF_OPPT, q.pch};
        d.proc = (q.pch == 2'd0) ? P_IDLE : P_FAN;
      end
      P_FAN: begin
        if (q.config_r[TFM_CFG_DYN]) begin
          if (q.pval > mem_b_rdata && q.start[p] != 8'h00) begin
            d.start[p] = 8'(q.start[p] - 8'd1);
          end else if (q.pval < mem_b_rdata && q.start[p] != 8'hff) begin
            d.start[p] = 8'(q.start[p] + 8'd1);
          end
        end
        if (q.pval > q.start[p]) begin
          diff = 8'(q.pval - q.start[p]);
        end
        slope = {8'h00, diff} << q.range[p][2:0];
        tgt = (slope[15:8] != 8'h00) ? 8'hff : slope[7:0];
        step = q.acous[p];
        cur = q.duty[p];
        if (step == 8'h00) begin
          d.duty[p] = tgt;
        end else if (cur < tgt) begin
          d.duty[p] = (8'(tgt - cur) > step) ? 8'(cur + step) : tgt;
        end else begin
          d.duty[p] = (8'(cur - tgt) > step) ? 8'(cur - step) : tgt;
        end
        d.proc = P_IDLE;
      end
      default: begin
        d.proc = P_IDLE;
      end
    endcase
    if (wr_en) begin
      if (q.ptr == TFM_PTR_CONFIG) begin
        d.config_r = q.sh;
      end else if (q.ptr == TFM_PTR_MASK) begin
        d.mask = q.sh;
      end else if (q.ptr[7:4] == TFM_PTR_MEM) begin
        mem_we = 1'b1;
      end else if (q.ptr[1:0] != 2'd3) begin
        if (q.ptr[7:2] == TFM_PTR_START[7:2]) begin
          d.start[q.ptr[1:0]] = q.sh;
        end else if (q.ptr[7:2] == TFM_PTR_RANGE[7:2]) begin
          d.range[q.ptr[1:0]] = q.sh;
        end else if (q.ptr[7:2] == TFM_PTR_ACOUS[7:2]) begin
          d.acous[q.ptr[1:0]] = q.sh;
        end
      end
    end
    d.status = (q.status & ~st_clr) | st_set;
    d.alert_a = d.config_r[TFM_CFG_ALERT_A] && ((d.status & ~d.mask) != 8'h00);
    d.alert_b = d.config_r[TFM_CFG_ALERT_B] && ((d.status & ~d.mask) != 8'h00);
    d.av_wait = !((avs_read || avs_write) && q.av_wait);
    if (avs_read && q.av_wait) begin
      unique case (avs_address)
        TFM_AV_STATUS: d.av_rdata = 32'(q.ev_status);
        TFM_AV_ENABLE: d.av_rdata = 32'(q.ev_en);
        TFM_AV_STATE: d.av_rdata = {9'h000, q.addr, q.config_r, q.status};
        default: d.av_rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && !q.av_wait && avs_byteenable[0]) begin
      if (avs_address == TFM_AV_ENABLE) begin
        d.ev_en = avs_writedata[TFM_NUM_EV-1:0];
      end else if (avs_address == TFM_AV_CLEAR) begin
        ev_clr = avs_writedata[TFM_NUM_EV-1:0];
      end
    end
    ev_set = '0;
    ev_set[TFM_EV_CYCLE] = cycle_done;
    ev_set[TFM_EV_LIMIT] = st_set != 8'h00;
    ev_set[TFM_EV_WRITE] = wr_en;
    d.ev_status = (q.ev_status & ~ev_clr) | ev_set;
    d.irq = (d.ev_status & d.ev_en) != '0;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '{smb: SM_IDLE, proc: P_IDLE, scl_q: 1'b1, sda_q: 1'b1, addr: TFM_ADDR_DEFAULT,
             config_r: TFM_CONFIG_RST, mask: TFM_MASK_RST, start: {3{TFM_START_RST}},
             range: {3{TFM_RANGE_RST}}, acous: {3{TFM_ACOUS_RST}}, av_wait: 1'b1,
             default: '0};
    end else begin
      q <= d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = q.sda_oe;
  assign alert_a_out = 1'b0;
  assign alert_a_oe = q.alert_a;
  assign alert_b_out = 1'b0;
  assign alert_b_oe = q.alert_b;
  assign fan_duty = q.duty;
  assign avs_readdata = q.av_rdata;
  assign avs_waitrequest = q.av_wait;
  assign irq = q.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence first_byte_s;
    q.smb == SM_WR && scl_fall && q.bitcnt == 4'd8 && q.bytecnt == 2'd0;
  endsequence
  sequence rd_done_s;
    q.smb == SM_RACK && scl_rise && !smb_start;
  endsequence

  strap_default_a: assert property ($rose(q.strap_done) && $past(addr_en_in)
    |-> q.addr == TFM_ADDR_DEFAULT) else $error("default address not taken");
  strap_select_a: assert property ($rose(q.strap_done) && !$past(addr_en_in)
    |-> q.addr == {TFM_ADDR_PREFIX, 1'b0, $past(addr_sel_in)}) else $error("bad strap address");
  addr_locked_a: assert property (q.strap_done |=> $stable(q.addr))
    else $error("slave address changed");
  pointer_load_a: assert property (first_byte_s |=> q.ptr == $past(q.sh) && q.sda_oe)
    else $error("pointer not loaded from first byte");
  single_read_a: assert property (rd_done_s |=> q.smb == SM_IDLE)
    else $error("read ran past one byte");
  alert_drive_a: assert property (q.alert_a == (q.config_r[TFM_CFG_ALERT_A]
    && (q.status & ~q.mask) != 8'h00)) else $error("alert a disagrees with status");
  mask_block_a: assert property ((q.status & ~q.mask) == 8'h00
    |-> !q.alert_a && !q.alert_b) else $error("masked event drove alert");
  limit_flag_a: assert property (q.proc == P_CMP && (q.plow || q.pval > mem_b_rdata)
    |=> q.status[$past(q.pch)]) else $error("out-of-limit not flagged");
  status_hold_a: assert property (1'b1 |=> (q.status & $past(held)) == $past(held))
    else $error("status cleared while condition present");
  result_taken_a: assert property (res_valid |-> q.proc == P_IDLE)
    else $error("conversion result arrived while busy");
endmodule

// file: tfm_smb_master.sv
`timescale 1ns/1ps
module tfm_smb_master (
  input wire logic mclk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (4) @(posedge mclk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    q();
    scl <= 1'b1;
    q();
    r = sda_in;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  // A write always leads with the pointer byte, then n data bytes.
  task automatic xfer_wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
      input int n, output logic [2:0] ak);
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
    send({a, 1'b0}, ak[0]);
    send(p, ak[1]);
    for (int k = 0; k < n; k++) send(k == 0 ? d : ~d, ak[2]);
    stop();
  endtask
  // A read takes one byte and ends with a no-acknowledge.
  task automatic xfer_rd(input logic [6:0] a, output logic [7:0] d, output logic ak);
    logic r;
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
    send({a, 1'b1}, ak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop();
  endtask
endmodule

// file: thermal_fan_monitor_core_tb.sv
`timescale 1ns/1ps
module thermal_fan_monitor_core_tb;
  import tfm_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic addr_en_in = 1'b1;
  logic addr_sel_in = 1'b0;
  logic adc_done = 1'b0;
  logic [7:0] adc_data = 8'h00;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic sda_out, sda_oe, alert_a_out, alert_a_oe, alert_b_out, alert_b_oe;
  logic adc_start, avs_waitrequest, irq, scl, m_low;
  logic [1:0] adc_ch, cv;
  logic [23:0] fan_duty;
  logic [31:0] avs_readdata;
  wire logic sda = !((sda_oe && !sda_out) || m_low);
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [6:0] dev;
  logic [7:0] raw [4];
  logic [1:0] exp_ch = 2'h0;
  initial forever #2.5 mclk = ~mclk;
  tfm_core dut_u (.mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_en_in(addr_en_in),
    .addr_sel_in(addr_sel_in), .alert_a_out(alert_a_out), .alert_a_oe(alert_a_oe),
    .alert_b_out(alert_b_out), .alert_b_oe(alert_b_oe), .adc_start(adc_start),
    .adc_ch(adc_ch), .adc_done(adc_done), .adc_data(adc_data), .fan_duty(fan_duty),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
  tfm_smb_master smb_u (.mclk(mclk), .sda_in(sda), .scl(scl), .sda_low(m_low));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    forever begin
      @(negedge mclk);
      if (adc_start === 1'b1) begin
        cv = adc_ch;
        chk("adc_ch", 32'(cv), 32'(exp_ch));
        exp_ch = exp_ch + 2'h1;
        repeat ($urandom_range(4, 1)) @(posedge mclk);
        adc_done <= 1'b1;
        adc_data <= raw[cv];
        @(posedge mclk);
        adc_done <= 1'b0;
        adc_data <= ~raw[cv];
      end
    end
  end
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic do_reset(input logic en, input logic sel);
    @(posedge mclk);
    reset <= 1'b1;
    addr_en_in <= en;
    addr_sel_in <= sel;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    exp_ch = 2'h0;
    dev = en ? 7'h2e : {5'h0b, 1'b0, sel};
    repeat (2) @(posedge mclk);
  endtask
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    logic [2:0] ak;
    smb_u.xfer_wr(dev, p, d, 1, ak);
  endtask
  task automatic rreg(input logic [7:0] p, output logic [7:0] d);
    logic [2:0] ak;
    smb_u.xfer_wr(dev, p, 8'h00, 0, ak);
    smb_u.xfer_rd(dev, d, ak[0]);
  endtask
  task automatic cyc_wait();
    logic [31:0] r;
    repeat (2) begin
      av(1'b1, 5'h08, 32'h1, r);
      do av(1'b0, 5'h00, 32'h0, r); while (r[0] !== 1'b1);
    end
  endtask
  function automatic logic [7:0] duty(input logic [7:0] t, input logic [7:0] s,
      input logic [2:0] r);
    logic [10:0] x;
    x = (t > s) ? {3'h0, 8'(t - s)} << r : 11'h000;
    return (x > 11'h0ff) ? 8'hff : x[7:0];
  endfunction
  initial begin
    logic [31:0] q;
    logic [7:0] d, e;
    logic [7:0] off [4];
    logic [2:0] ak;
    logic [7:0] st0;
    logic [2:0] rg0;
    void'($urandom(13));
    for (int s = 0; s < 3; s++) begin
      do_reset(s == 0, s == 2);
      av(1'b0, 5'h0c, 32'h0, q);
      chk("addr", 32'(q[22:16]), 32'(dev));
      smb_u.xfer_wr(dev, 8'h40, 8'h00, 1, ak);
      chk("ack", 32'(ak[1:0]), 32'h3);
      smb_u.xfer_wr(dev ^ 7'h01, 8'h40, 8'h00, 0, ak);
      chk("nack", 32'(ak[0]), 32'h0);
    end
    av(1'b0, 5'h04, 32'h0, q);
    chk("en_rst", q, 32'h0);
    av(1'b0, 5'h10, 32'h0, q);
    chk("unmapped", q, 32'h0);
    av(1'b1, 5'h08, 32'h7, q);
    av(1'b1, 5'h04, 32'h4, q);
    repeat (2) @(posedge mclk);
    chk("irq_idle", 32'(irq), 32'h0);
    wreg(8'h42, 8'h00);
    av(1'b0, 5'h00, 32'h0, q);
    chk("ev_write", q, 32'h4);
    chk("irq_set", 32'(irq), 32'h1);
    av(1'b1, 5'h08, 32'h4, q);
    av(1'b0, 5'h00, 32'h0, q);
    chk("ev_clr", q, 32'h0);
    chk("irq_clr", 32'(irq), 32'h0);
    for (int c = 0; c < 4; c++) begin
      raw[c] = 8'($urandom_range(8'h6f, 8'h20));
      off[c] = 8'($urandom_range(31, 0)) - 8'h10;
    end
    off[0] = 8'h00;
    off[2] = 8'h01;
    for (int c = 1; c < 4; c++) wreg(8'h50 + 8'(c), off[c]);
    st0 = 8'($urandom_range(8'h40, 8'h20));
    rg0 = 3'($urandom_range(3, 0));
    wreg(8'h60, st0);
    wreg(8'h64, {5'h00, rg0});
    rreg(8'h60, d);
    chk("start", 32'(d), 32'(st0));
    wreg(8'h5a, 8'h00);
    smb_u.xfer_wr(dev, 8'h40, 8'h03, 2, ak);
    chk("third", 32'(ak), 32'h3);
    rreg(8'h40, d);
    chk("config", 32'(d), 32'h03);
    cyc_wait();
    av(1'b0, 5'h00, 32'h0, q);
    chk("ev_limit", 32'(q[1]), 32'h1);
    for (int c = 0; c < 4; c++) begin
      rreg(8'h20 + 8'(c), d);
      e = raw[c] + off[c];
      chk("value", 32'(d), 32'(e));
    end
    for (int p = 0; p < 3; p++) begin
      e = raw[p + 1] + off[p + 1];
      e = duty(e, (p == 0) ? st0 : TFM_START_RST, (p == 0) ? rg0 : TFM_RANGE_RST[2:0]);
      chk("duty", 32'(fan_duty[8*p +: 8]), 32'(e));
    end
    rreg(8'h41, d);
    chk("status", 32'(d), 32'h04);
    for (int k = 0; k < 2; k++) begin
      d = (k == 1) ? 8'h05 : 8'h03;
      wreg(8'h40, d);
      chk("alert_a", 32'(alert_a_oe), 32'(d[1]));
      chk("alert_b", 32'(alert_b_oe), 32'(d[2]));
    end
    chk("alert_pin", 32'(alert_b_out), 32'h0);
    wreg(8'h42, 8'h04);
    chk("masked", 32'(alert_b_oe), 32'h0);
    wreg(8'h42, 8'h00);
    wreg(8'h5a, 8'hff);
    cyc_wait();
    chk("sticky", 32'(alert_b_oe), 32'h1);
    rreg(8'h41, d);
    chk("st_first", 32'(d), 32'h04);
    rreg(8'h41, d);
    chk("st_clear", 32'(d), 32'h00);
    chk("alert_off", 32'(alert_b_oe), 32'h0);
    av(1'b0, 5'h0c, 32'h0, q);
    chk("state", 32'(q[15:8]), 32'h05);
    wreg(8'h5d, 8'h00);
    wreg(8'h40, 8'h0d);
    cyc_wait();
    rreg(8'h60, d);
    chk("dyn_start", 32'(d < st0), 32'h1);
    stop_test();
  end
endmodule
